// *** rtl/rpp_pkg.sv ***
// Package: register map, field layout and carrier types for rx port paging
package rpp_pkg;
    localparam int          NUM_PORTS       = 2;
    localparam logic [7:0]  ADDR_LINK_CAP   = 8'h4a;
    localparam logic [7:0]  ADDR_EMBED_CTL  = 8'h4b;
    localparam logic [7:0]  ADDR_PORT_SEL   = 8'h4c;
    localparam logic [7:0]  ADDR_PORT_STS1  = 8'h4d;
    localparam logic [7:0]  PAGE_A_LO       = 8'h4d;
    localparam logic [7:0]  PAGE_A_HI       = 8'h7f;
    localparam logic [7:0]  PAGE_B_LO       = 8'hd0;
    localparam logic [7:0]  PAGE_B_HI       = 8'hdf;
    localparam logic [7:0]  LINK_CAP_RST    = 8'h00;
    localparam logic [7:0]  EMBED_CTL_RST   = 8'h12;
    localparam int          CRC_CAP_BIT     = 4;
    localparam int          EMB_CNT_HI      = 7;
    localparam int          EMB_CNT_LO      = 6;
    localparam int          EMB_ID_HI       = 5;
    localparam int          EMB_ID_LO       = 0;
    localparam int          SEL_PHYS_BIT    = 6;
    localparam int          SEL_RD_BIT      = 4;
    localparam int          SEL_WR1_BIT     = 1;
    localparam int          SEL_WR0_BIT     = 0;
    localparam int          STS1_PORT_BIT   = 6;
    // Page state copies: local path, control channel on port 0, on port 1
    localparam int          NUM_SRC         = 3;
    localparam logic [1:0]  SRC_LOCAL       = 2'h0;
    localparam logic [1:0]  SRC_BCC0        = 2'h1;
    localparam logic [1:0]  SRC_BCC1        = 2'h2;

    typedef struct packed {
        logic       rd_port;
        logic [1:0] wr_en;
    } rpp_sel_t;

    localparam rpp_sel_t    SEL_RST_LOCAL   = '{rd_port: 1'b0, wr_en: 2'h0};
    localparam rpp_sel_t    SEL_RST_BCC0    = '{rd_port: 1'b0, wr_en: 2'h1};
    localparam rpp_sel_t    SEL_RST_BCC1    = '{rd_port: 1'b1, wr_en: 2'h2};

    typedef struct packed {
        logic       valid;
        logic       write;
        logic       bcc;
        logic       bcc_port;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rpp_req_t;
endpackage

// *** rtl/rpp_port_paging.sv ***
// Rx port paging, per-port capability and embedded data type substitution
// Contract
// RULE_01: Paged register accesses go to the port or ports chosen by port select.
// RULE_02: Bit 4 of port select chooses the single port read back.
// RULE_03: Read port resets to 0 locally, to the carrying port over control channel.
// RULE_04: Bits 1 and 0 gate paged writes; both set broadcasts to both ports.
// RULE_05: Write enables reset 0 locally; carrying port's enable is 1 over channel.
// RULE_06: Bit 6 reads 0 locally and the carrying port over control channel.
// RULE_07: Each access source keeps its own port select page state.
// RULE_08: Per-port bit 4 of link capabilities gates the encoder CRC error flag.
// RULE_09: Software sets the capability bit and clears the encoder CRC disable.
// RULE_10: Embedded count 00 forwards every long packet with normal raw type.
// RULE_11: Count 1 to 3 sends that many first long packets as embedded data.
// RULE_12: Embedded settings do nothing when the port receives CSI-2 input.
// RULE_13: First N lines use the six-bit embedded type, which resets to 0x12.
// RULE_14: Status bit 6 at 0x4d reports the currently selected read port.
// RULE_15: Paged write with no enable changes nothing and is still acknowledged.
`timescale 1ns/1ps
module rpp_port_paging
    import rpp_pkg::*;
(
    input  wire logic                  sys_clk_i,
    input  wire logic                  rst_i,
    input  wire rpp_req_t              req_i,
    output logic                       ack_o,
    output logic [7:0]                 rd_data_o,
    output logic [NUM_PORTS-1:0]       ext_wr_port_o,
    output logic                       ext_rd_port_o,
    input  wire logic [NUM_PORTS-1:0]  crc_err_i,
    output logic [NUM_PORTS-1:0]       crc_err_flag_o,
    input  wire logic [NUM_PORTS-1:0]  csi_mode_i,
    input  wire logic [NUM_PORTS-1:0]  raw12_mode_i,
    input  wire logic [5:0]            raw12_data_type_value_i,
    input  wire logic [5:0]            raw10_data_type_value_i,
    input  wire logic [NUM_PORTS-1:0]  frame_start_i,
    input  wire logic [NUM_PORTS-1:0]  long_pkt_i,
    output logic [NUM_PORTS-1:0]       dtype_valid_o,
    output logic [NUM_PORTS-1:0][5:0]  dtype_o
);

    // Window of per-port registers; unimplemented ones still strobe outside
    function automatic logic is_paged(input logic [7:0] a);
        is_paged = (a == ADDR_LINK_CAP) || (a == ADDR_EMBED_CTL)
                || (a >= PAGE_A_LO && a <= PAGE_A_HI)
                || (a >= PAGE_B_LO && a <= PAGE_B_HI);
    endfunction

    // Index into the page state copies for the requesting source
    function automatic logic [1:0] src_of(input logic bcc, input logic port);
        if (!bcc)
            src_of = SRC_LOCAL;
        else if (port)
            src_of = SRC_BCC1;
        else
            src_of = SRC_BCC0;
    endfunction

    rpp_sel_t                sel_reg [NUM_SRC];
    logic [7:0]              cap_reg [NUM_PORTS];
    logic [7:0]              emb_reg [NUM_PORTS];
    logic [1:0]              src;
    rpp_sel_t                cur_sel;
    logic                    phys_port;
    logic                    paged_wr;
    logic [7:0]              rd_data_next;

    assign src       = src_of(req_i.bcc, req_i.bcc_port);
    assign cur_sel   = sel_reg[src];
    assign phys_port = req_i.bcc & req_i.bcc_port;
    assign paged_wr  = req_i.valid & req_i.write & is_paged(req_i.addr);

    // Separate page state per source; a remote host cannot steal local paging
    genvar s;
    generate
        for (s = 0; s < NUM_SRC; s++)
        begin : g_src
            localparam rpp_sel_t RST = (s == 0) ? SEL_RST_LOCAL :
                                       (s == 1) ? SEL_RST_BCC0 : SEL_RST_BCC1;
            always_ff @(posedge sys_clk_i)
            begin
                if (rst_i)
                    sel_reg[s] <= RST;                             // see RULE_03 see RULE_05
                else if (req_i.valid && req_i.write && req_i.addr == ADDR_PORT_SEL
                         && src == 2'(s))                          // see RULE_07
                begin
                    sel_reg[s].rd_port  <= req_i.wdata[SEL_RD_BIT];
                    sel_reg[s].wr_en[1] <= req_i.wdata[SEL_WR1_BIT];
                    sel_reg[s].wr_en[0] <= req_i.wdata[SEL_WR0_BIT];
                end
            end
        end
    endgenerate

    // Per-port paged storage, broadcast when several enables are set
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++)
        begin : g_port
            logic [1:0] pkt_cnt_reg;
            logic [1:0] emb_n;
            logic       use_emb;

            always_ff @(posedge sys_clk_i)
            begin
                if (rst_i)
                begin
                    cap_reg[p] <= LINK_CAP_RST;
                    emb_reg[p] <= EMBED_CTL_RST;                   // see RULE_13
                end
                else if (paged_wr && cur_sel.wr_en[p])             // see RULE_01 see RULE_04 see RULE_15
                begin
                    if (req_i.addr == ADDR_LINK_CAP)
                        cap_reg[p] <= req_i.wdata;
                    if (req_i.addr == ADDR_EMBED_CTL)
                        emb_reg[p] <= req_i.wdata;
                end
            end

            always_ff @(posedge sys_clk_i)
            begin
                if (rst_i)
                    crc_err_flag_o[p] <= 1'b0;
                else
                    crc_err_flag_o[p] <= crc_err_i[p] & cap_reg[p][CRC_CAP_BIT]; // see RULE_08
            end

            assign emb_n   = emb_reg[p][EMB_CNT_HI:EMB_CNT_LO];
            assign use_emb = !csi_mode_i[p] && (pkt_cnt_reg < emb_n);      // see RULE_10 see RULE_12

            // Counter saturates at 3 so long frames never wrap into embedded again
            always_ff @(posedge sys_clk_i)
            begin
                if (rst_i || frame_start_i[p])
                    pkt_cnt_reg <= 2'h0;
                else if (long_pkt_i[p] && pkt_cnt_reg != 2'h3)
                    pkt_cnt_reg <= pkt_cnt_reg + 2'h1;
            end

            always_ff @(posedge sys_clk_i)
            begin
                if (rst_i)
                begin
                    dtype_valid_o[p] <= 1'b0;
                    dtype_o[p]       <= 6'h00;
                end
                else
                begin
                    dtype_valid_o[p] <= long_pkt_i[p] && !frame_start_i[p];
                    if (long_pkt_i[p] && !frame_start_i[p])
                    begin
                        if (use_emb)
                            dtype_o[p] <= emb_reg[p][EMB_ID_HI:EMB_ID_LO]; // see RULE_11 see RULE_13
                        else if (raw12_mode_i[p])
                            dtype_o[p] <= raw12_data_type_value_i;
                        else
                            dtype_o[p] <= raw10_data_type_value_i;
                    end
                end
            end

            // Packet path checks, one cycle after the packet is taken
            property p_emb_n;
                @(posedge sys_clk_i) disable iff (rst_i)
                (long_pkt_i[p] && !frame_start_i[p] && !csi_mode_i[p]
                 && pkt_cnt_reg < emb_n)
                |=> dtype_o[p] == $past(emb_reg[p][EMB_ID_HI:EMB_ID_LO]);
            endproperty
            a_emb_n: assert property (p_emb_n)                     // see RULE_11
                else $error("embedded type not used for early packet");

            property p_raw_pass;
                @(posedge sys_clk_i) disable iff (rst_i)
                (long_pkt_i[p] && !frame_start_i[p] && emb_n == 2'h0 && !raw12_mode_i[p])
                |=> dtype_o[p] == $past(raw10_data_type_value_i);
            endproperty
            a_raw_pass: assert property (p_raw_pass)               // see RULE_10
                else $error("raw type not used with embedded count zero");

            property p_csi_off;
                @(posedge sys_clk_i) disable iff (rst_i)
                (long_pkt_i[p] && !frame_start_i[p] && csi_mode_i[p] && raw12_mode_i[p])
                |=> dtype_o[p] == $past(raw12_data_type_value_i);
            endproperty
            a_csi_off: assert property (p_csi_off)                 // see RULE_12
                else $error("embedded type used in csi mode");

            // Flag uses the capability seen at the same edge, not the new value
            property p_crc_gate;
                @(posedge sys_clk_i) disable iff (rst_i)
                !cap_reg[p][CRC_CAP_BIT] |=> !crc_err_flag_o[p];
            endproperty
            a_crc_gate: assert property (p_crc_gate)               // see RULE_08
                else $error("crc flag raised while capability clear");

            property p_wr_gate;
                @(posedge sys_clk_i) disable iff (rst_i)
                (req_i.valid && req_i.write && !cur_sel.wr_en[p])
                |=> $stable(cap_reg[p]) && $stable(emb_reg[p]);
            endproperty
            a_wr_gate: assert property (p_wr_gate)                 // see RULE_04 see RULE_15
                else $error("paged register changed without write enable");

            property p_wr_take;
                @(posedge sys_clk_i) disable iff (rst_i)
                (req_i.valid && req_i.write && req_i.addr == ADDR_EMBED_CTL
                 && cur_sel.wr_en[p])
                |=> emb_reg[p] == $past(req_i.wdata);
            endproperty
            a_wr_take: assert property (p_wr_take)                 // see RULE_01
                else $error("enabled paged write not stored");
        end
    endgenerate

    // Readback follows the requester's own read port, never another source's
    always_comb
    begin
        rd_data_next = 8'h00;
        case (req_i.addr)
            ADDR_PORT_SEL:
            begin
                rd_data_next[SEL_PHYS_BIT] = phys_port;                   // see RULE_06
                rd_data_next[SEL_RD_BIT]   = cur_sel.rd_port;
                rd_data_next[SEL_WR1_BIT]  = cur_sel.wr_en[1];
                rd_data_next[SEL_WR0_BIT]  = cur_sel.wr_en[0];
            end
            ADDR_LINK_CAP:  rd_data_next = cap_reg[cur_sel.rd_port];      // see RULE_02
            ADDR_EMBED_CTL: rd_data_next = emb_reg[cur_sel.rd_port];
            ADDR_PORT_STS1: rd_data_next[STS1_PORT_BIT] = cur_sel.rd_port; // see RULE_14
            default:        rd_data_next = 8'h00;
        endcase
    end

    // Every access is acknowledged, gated writes included
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            ack_o     <= 1'b0;
            rd_data_o <= 8'h00;
        end
        else
        begin
            ack_o <= req_i.valid;                                         // see RULE_15
            if (req_i.valid && !req_i.write)
                rd_data_o <= rd_data_next;
        end
    end

    // Strobes for paged registers held outside this block
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            ext_wr_port_o <= 2'h0;
            ext_rd_port_o <= 1'b0;
        end
        else
        begin
            ext_wr_port_o <= paged_wr ? cur_sel.wr_en : 2'h0;             // see RULE_01
            ext_rd_port_o <= cur_sel.rd_port;
        end
    end

    // Register access checks
    property p_ack;
        @(posedge sys_clk_i) disable iff (rst_i)
        req_i.valid |=> ack_o;
    endproperty
    a_ack: assert property (p_ack)                                // see RULE_15
        else $error("access not acknowledged");

    property p_rd_sel;
        @(posedge sys_clk_i) disable iff (rst_i)
        (req_i.valid && !req_i.write && req_i.addr == ADDR_LINK_CAP)
        |=> rd_data_o == $past(cap_reg[cur_sel.rd_port]);
    endproperty
    a_rd_sel: assert property (p_rd_sel)                          // see RULE_02
        else $error("readback from wrong port");

    property p_phys;
        @(posedge sys_clk_i) disable iff (rst_i)
        (req_i.valid && !req_i.write && req_i.addr == ADDR_PORT_SEL)
        |=> rd_data_o[SEL_PHYS_BIT] == $past(req_i.bcc && req_i.bcc_port);
    endproperty
    a_phys: assert property (p_phys)                              // see RULE_06
        else $error("physical port field wrong");

    property p_iso;
        @(posedge sys_clk_i) disable iff (rst_i)
        (req_i.valid && req_i.bcc) |=> $stable(sel_reg[SRC_LOCAL]);
    endproperty
    a_iso: assert property (p_iso)                                // see RULE_07
        else $error("local page state disturbed by remote source");

    // No disable here: the check is about what reset itself leaves behind
    property p_rst_bcc1;
        @(posedge sys_clk_i)
        rst_i |=> sel_reg[SRC_BCC1] == SEL_RST_BCC1 && sel_reg[SRC_LOCAL] == SEL_RST_LOCAL;
    endproperty
    a_rst_bcc1: assert property (p_rst_bcc1)                      // see RULE_03 see RULE_05
        else $error("control channel page default wrong");

endmodule

// *** sim/rpp_host_model.sv ***
// Host side model: single-byte register accesses over local or channel path
`timescale 1ns/1ps
module rpp_host_model
    import rpp_pkg::*;
(
    input  wire logic sys_clk_i,
    output rpp_req_t  req_o
);
    initial req_o = '0;

    // Released fields are inverted so a stale address never looks valid
    task automatic access(input logic bcc, input logic port, input logic wr,
                          input logic [7:0] addr, input logic [7:0] wd);
        @(negedge sys_clk_i);
        req_o = '{valid: 1'b1, write: wr, bcc: bcc, bcc_port: port, addr: addr, wdata: wd};
        @(negedge sys_clk_i);
        req_o.valid = 1'b0;
        req_o.addr  = ~addr;
        req_o.wdata = ~wd;
    endtask
endmodule

// *** sim/test_rpp_port_paging.sv ***
// Self-checking bench for rx port paging and embedded data type substitution
`timescale 1ns/1ps
module test_rpp_port_paging
    import rpp_pkg::*;
;
    typedef struct packed {
        logic       rd;
        logic [1:0] mask;
        logic       rp;
        logic [7:0] data;
    } rpp_exp_t;

    logic            sys_clk_i = 1'b0;
    logic            rst_i     = 1'b1;
    rpp_req_t        req;
    logic            ack, ext_rd;
    logic [7:0]      rd_data;
    logic [1:0]      ext_wr, crc_err, crc_flag, csi, r12, fs, lp, dv, exp_crc;
    logic [5:0]      id12, id10;
    logic [1:0][5:0] dt;
    logic [7:0]      cap [2];
    logic [7:0]      emb [2];
    rpp_sel_t        sel [3];
    rpp_exp_t        qa[$];
    rpp_exp_t        me;
    logic [6:0]      qp[$];
    int              error_cnt   = 0;
    int              check_count = 0;

    always #50 sys_clk_i = ~sys_clk_i;

    rpp_host_model host (.sys_clk_i(sys_clk_i), .req_o(req));

    rpp_port_paging dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req), .ack_o(ack), .rd_data_o(rd_data),
        .ext_wr_port_o(ext_wr), .ext_rd_port_o(ext_rd), .crc_err_i(crc_err),
        .crc_err_flag_o(crc_flag), .csi_mode_i(csi), .raw12_mode_i(r12),
        .raw12_data_type_value_i(id12), .raw10_data_type_value_i(id10),
        .frame_start_i(fs), .long_pkt_i(lp), .dtype_valid_o(dv), .dtype_o(dt)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (error_cnt == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Expectation comes from the bench's own page and register model
    task automatic acc(input logic bcc, input logic p, input logic wr, input logic [7:0] a,
                       input logic [7:0] wd);
        int       s;
        logic     pg;
        rpp_exp_t e;
        s  = bcc ? (p ? 2 : 1) : 0;
        pg = a == ADDR_LINK_CAP || a == ADDR_EMBED_CTL || (a >= PAGE_A_LO && a <= PAGE_A_HI)
             || (a >= PAGE_B_LO && a <= PAGE_B_HI);
        e  = '{rd: !wr, mask: (wr && pg) ? sel[s].wr_en : 2'h0, rp: sel[s].rd_port, data: 8'h00};
        if (!wr && a == ADDR_LINK_CAP)
            e.data = cap[sel[s].rd_port];
        if (!wr && a == ADDR_EMBED_CTL)
            e.data = emb[sel[s].rd_port];
        if (!wr && a == ADDR_PORT_SEL)
            e.data = {1'b0, bcc & p, 1'b0, sel[s].rd_port, 2'b00, sel[s].wr_en};
        if (!wr && a == ADDR_PORT_STS1)
            e.data = {1'b0, sel[s].rd_port, 6'h00};
        if (wr && a == ADDR_PORT_SEL)
            sel[s] = '{rd_port: wd[4], wr_en: wd[1:0]};
        for (int i = 0; i < 2; i++)
        begin
            if (e.mask[i] && a == ADDR_LINK_CAP)
                cap[i] = wd;
            if (e.mask[i] && a == ADDR_EMBED_CTL)
                emb[i] = wd;
        end
        qa.push_back(e);
        host.access(bcc, p, wr, a, wd);
    endtask

    // One frame of five back-to-back long packets on port p
    task automatic pkts(input int p, input logic c, input logic m);
        @(negedge sys_clk_i);
        csi[p] = c;
        r12[p] = m;
        fs[p]  = 1'b1;
        @(negedge sys_clk_i);
        fs[p]  = 1'b0;
        for (int k = 0; k < 5; k++)
        begin
            lp[p]   = 1'b1;
            crc_err = 2'($urandom_range(3, 0));
            qp.push_back({p[0], (!c && k < emb[p][7:6]) ? emb[p][5:0] : (m ? id12 : id10)});
            @(negedge sys_clk_i);
        end
        lp      = 2'h0;
        crc_err = 2'h0;
        repeat (2) @(negedge sys_clk_i);
    endtask

    always @(posedge sys_clk_i)
        exp_crc <= crc_err & {cap[1][CRC_CAP_BIT], cap[0][CRC_CAP_BIT]};

    always @(negedge sys_clk_i)
    begin
        if (ack === 1'b1)
        begin
            me = (qa.size() > 0) ? qa.pop_front() : '1;
            chk(ext_wr, me.mask);
            chk(ext_rd, me.rp);
            if (me.rd)
                chk(rd_data, me.data);
        end
        for (int p = 0; p < 2; p++)
            if (dv[p] === 1'b1)
                chk({p[0], dt[p]}, (qp.size() > 0) ? qp.pop_front() : 7'h7f);
        if (!rst_i)
            chk(crc_flag, exp_crc);
    end

    initial
    begin
        {crc_err, csi, r12, fs, lp} = '0;
        void'($urandom(20));
        id12 = 6'($urandom);
        id10 = 6'($urandom);
        cap  = '{LINK_CAP_RST, LINK_CAP_RST};
        emb  = '{EMBED_CTL_RST, EMBED_CTL_RST};
        sel  = '{SEL_RST_LOCAL, SEL_RST_BCC0, SEL_RST_BCC1};
        repeat (12) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        rst_i = 1'b0;
        for (int s = 0; s < 3; s++)
            for (int a = 8'h4a; a <= 8'h4d; a++)
                acc(s != 0, s == 2, 1'b0, 8'(a), 8'h00);
        acc(1'b0, 1'b0, 1'b0, 8'h44, 8'h00);
        acc(1'b0, 1'b0, 1'b0, 8'h50, 8'h00);
        acc(1'b0, 1'b0, 1'b1, ADDR_PORT_SEL, 8'hff);
        acc(1'b0, 1'b0, 1'b0, ADDR_PORT_SEL, 8'h00);
        acc(1'b0, 1'b0, 1'b1, ADDR_EMBED_CTL, 8'($urandom));
        acc(1'b0, 1'b0, 1'b0, ADDR_EMBED_CTL, 8'h00);
        acc(1'b0, 1'b0, 1'b1, ADDR_PORT_SEL, 8'h00);
        acc(1'b0, 1'b0, 1'b1, ADDR_LINK_CAP, 8'($urandom));
        acc(1'b0, 1'b0, 1'b0, ADDR_LINK_CAP, 8'h00);
        acc(1'b1, 1'b1, 1'b1, ADDR_LINK_CAP, 8'h10);
        acc(1'b1, 1'b1, 1'b0, ADDR_LINK_CAP, 8'h00);
        acc(1'b1, 1'b1, 1'b0, ADDR_PORT_STS1, 8'h00);
        acc(1'b0, 1'b0, 1'b0, ADDR_PORT_SEL, 8'h00);
        for (int p = 0; p < 2; p++)
            for (int n = 0; n < 4; n++)
            begin
                acc(1'b0, 1'b0, 1'b1, ADDR_PORT_SEL, 8'(1 << p));
                acc(1'b0, 1'b0, 1'b1, ADDR_EMBED_CTL, {2'(n), 6'($urandom)});
                pkts(p, 1'b0, n[0]);
                if (n == 3)
                    pkts(p, 1'b1, 1'b1);
            end
        repeat (3) @(negedge sys_clk_i);
        chk(qa.size() + qp.size(), 0);
        conclude();
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        error_cnt++;
        conclude();
    end
endmodule
